// ### logic/pcr_ctrl.sv
// transceiver control register with its decoded control outputs
`timescale 1ns/10ps

// Behaviour
// - tx fifo depth from bits 15:14: 11=8, 10=6, 01=4, 00=3; reset 01
// - tx fifo used at 1000 with gmii-style, or any speed with serial mode
// - rx fifo depth from bits 13:12, same coding; reset 01
// - rx fifo used only in serial mode, bypassed otherwise
// - bit 11 selects serial gigabit mac mode; reset from strap
// - bit 10 forces link good at selected speed; reset 0
// - power code 11 powers blocks down but leaves the pll up; 00 normal
// - code 10 sleeps, pulses every 1.4 s, wakes on partner detect
// - code 01 powers blocks down, and pll too when clock output enabled
// - bit 7 turns pin or basic control power-down into deep power-down
// - bits 6:5: 1x auto crossover, 01 mdi-x, 00 mdi; reset 10 or strap
// - bit 4 stops the 125 MHz clock output; reset 0
// - bit 3 reads 1, writes ignored
// - bit 2 standby: circuits powered, no link allowed
// - bit 1 inverts line driver polarity
// - bit 0 disables jabber detection
module pcr_ctrl
    import pcr_pkg::*;
#(
    parameter bit PAIR_FROM_STRAP = 1'b0,
    parameter int PULSE_PERIOD    = PULSE_CYCLES
) (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // straps
    input  wire logic        strap_serial,
    input  wire logic [1:0]  strap_pair_swap,
    // management register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    output logic             reg_rvalid,
    // device status in
    input  wire logic [1:0]  link_speed,
    input  wire logic        mac_gmii_style,
    input  wire logic        partner_detect,
    input  wire logic        pd_pin,
    input  wire logic        basic_control_reg_pd,
    // fifo control
    output logic [3:0]       tx_fifo_depth,
    output logic             tx_fifo_en,
    output logic [3:0]       rx_fifo_depth,
    output logic             rx_fifo_en,
    // mode control
    output logic             serial_mode,
    output logic             force_link_good,
    output logic             auto_pair_swap,
    output logic             pair_swap_select,
    output logic             ref_clock_out_en,
    output logic             link_block,
    output logic             tx_polarity_flip,
    output logic             jabber_en,
    // power control
    output logic             blocks_pd,
    output logic             pll_pd,
    output logic             deep_pd,
    output logic             std_pd,
    output logic             link_pulse,
    output logic             sleeping
);

    // ----------------------------------------
    // register storage and access
    // ----------------------------------------
    logic [15:0] ctl_reg;
    logic [15:0] ctl_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        rvalid_reg;
    logic        rvalid_next;
    logic [15:0] rst_val;
    logic        hit;
    logic [1:0]  pair_rst;

    assign hit      = (reg_addr == PCR_ADDR);
    assign pair_rst = PAIR_FROM_STRAP ? strap_pair_swap : PAIR_RST;

    always_comb begin
        rst_val                       = '0;
        rst_val[TXD_HI:TXD_LO]        = TXD_RST;
        rst_val[RXD_HI:RXD_LO]        = RXD_RST;
        rst_val[SER_EN_BIT]           = strap_serial;
        rst_val[LINK_OVR_BIT]         = BIT_CLR;
        rst_val[PS_HI:PS_LO]          = PS_RST;
        rst_val[PAIR_HI:PAIR_LO]      = pair_rst;
        rst_val[CLK_DIS_BIT]          = BIT_CLR;
        rst_val[FIXED_BIT]            = BIT_SET;
    end

    always_comb begin
        ctl_next    = ctl_reg;
        rdata_next  = rdata_reg;
        rvalid_next = 1'b0;
        if (hit && reg_wr) begin
            ctl_next = (reg_wdata & WR_MASK) | FIXED_ONES;
        end
        if (hit && reg_rd) begin
            rdata_next  = ctl_reg | FIXED_ONES;
            rvalid_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_reg    <= rst_val;
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else if (ce) begin
            ctl_reg    <= ctl_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata  = rdata_reg;
    assign reg_rvalid = rvalid_reg;

    // ----------------------------------------
    // power state machine
    // ----------------------------------------
    pcr_pwr_e    pwr_reg;
    pcr_pwr_e    pwr_next;
    logic [1:0]  ps_code;

    assign ps_code = ctl_reg[PS_HI:PS_LO];

    always_comb begin
        pwr_next = pwr_reg;
        unique case (ps_code)
            PS_NORMAL:  pwr_next = PWR_NORMAL;
            PS_IEEE:    pwr_next = PWR_IEEE;
            PS_PASSIVE: pwr_next = PWR_PASSIVE;
            PS_ACTIVE: begin
                if (pwr_reg == PWR_ACT_WAKE) begin
                    pwr_next = PWR_ACT_WAKE;
                end else if (pwr_reg == PWR_ACT_SLEEP && partner_detect) begin
                    pwr_next = PWR_ACT_WAKE;
                end else begin
                    pwr_next = PWR_ACT_SLEEP;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_reg <= PWR_NORMAL;
        end else if (ce) begin
            pwr_reg <= pwr_next;
        end
    end

    // ----------------------------------------
    // decoded outputs
    // ----------------------------------------
    logic [3:0] txd_reg;
    logic [3:0] txd_next;
    logic [3:0] rxd_reg;
    logic [3:0] rxd_next;
    logic       txen_reg;
    logic       txen_next;
    logic       rxen_reg;
    logic       rxen_next;
    logic       bpd_reg;
    logic       bpd_next;
    logic       pll_reg;
    logic       pll_next;
    logic       deep_reg;
    logic       deep_next;
    logic       stdpd_reg;
    logic       stdpd_next;
    logic       clkout_reg;
    logic       clkout_next;
    logic       pd_req;
    logic       ser;

    assign ser    = ctl_reg[SER_EN_BIT];
    assign pd_req = pd_pin | basic_control_reg_pd;

    always_comb begin
        txd_next    = pcr_depth(ctl_reg[TXD_HI:TXD_LO]);
        rxd_next    = pcr_depth(ctl_reg[RXD_HI:RXD_LO]);
        txen_next   = ser ||
                      (mac_gmii_style && link_speed == SPEED_1000);
        rxen_next   = ser;
        bpd_next    = (pwr_reg == PWR_IEEE) ||
                      (pwr_reg == PWR_ACT_SLEEP) ||
                      (pwr_reg == PWR_PASSIVE);
        pll_next    = (pwr_reg == PWR_IEEE) && !ctl_reg[CLK_DIS_BIT];
        deep_next   = pd_req && ctl_reg[DEEP_PD_BIT];
        stdpd_next  = pd_req && !ctl_reg[DEEP_PD_BIT];
        clkout_next = !ctl_reg[CLK_DIS_BIT];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txd_reg    <= DEPTH_4;
            rxd_reg    <= DEPTH_4;
            txen_reg   <= 1'b0;
            rxen_reg   <= 1'b0;
            bpd_reg    <= 1'b0;
            pll_reg    <= 1'b0;
            deep_reg   <= 1'b0;
            stdpd_reg  <= 1'b0;
            clkout_reg <= 1'b1;
        end else if (ce) begin
            txd_reg    <= txd_next;
            rxd_reg    <= rxd_next;
            txen_reg   <= txen_next;
            rxen_reg   <= rxen_next;
            bpd_reg    <= bpd_next;
            pll_reg    <= pll_next;
            deep_reg   <= deep_next;
            stdpd_reg  <= stdpd_next;
            clkout_reg <= clkout_next;
        end
    end

    assign tx_fifo_depth    = txd_reg;
    assign rx_fifo_depth    = rxd_reg;
    assign tx_fifo_en       = txen_reg;
    assign rx_fifo_en       = rxen_reg;
    assign blocks_pd        = bpd_reg;
    assign pll_pd           = pll_reg;
    assign deep_pd          = deep_reg;
    assign std_pd           = stdpd_reg;
    assign ref_clock_out_en = clkout_reg;
    assign sleeping         = (pwr_reg == PWR_ACT_SLEEP);

    // direct field outputs from stored bits, jabber_en inverted, pair_swap_select decoded
    assign serial_mode      = ser;
    assign force_link_good  = ctl_reg[LINK_OVR_BIT];
    assign auto_pair_swap   = ctl_reg[PAIR_HI];
    assign pair_swap_select = (ctl_reg[PAIR_HI:PAIR_LO] == PAIR_MDIX);
    assign link_block       = ctl_reg[STANDBY_BIT];
    assign tx_polarity_flip = ctl_reg[POL_FLIP_BIT];
    assign jabber_en        = !ctl_reg[JAB_DIS_BIT];

    // ----------------------------------------
    // link pulses in active sleep
    // ----------------------------------------
    pcr_wake_pulse #(
        .PERIOD (PULSE_PERIOD)
    ) u_pulse (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .run    (sleeping),
        .pulse  (link_pulse)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_bit3_reads_one: assert property (@(posedge clk) disable iff (rst)
        reg_rvalid |-> reg_rdata[FIXED_BIT])
        else $error("fixed bit read as zero");

    a_write_applies: assert property (@(posedge clk) disable iff (rst)
        ce && hit && reg_wr |=>
        ctl_reg == (($past(reg_wdata) & WR_MASK) | FIXED_ONES))
        else $error("write not stored");

    a_read_returns: assert property (@(posedge clk) disable iff (rst)
        ce && hit && reg_rd && !reg_wr |=>
        reg_rvalid && reg_rdata == ctl_reg)
        else $error("read data differs from stored value");

    a_rvalid_pulse: assert property (@(posedge clk) disable iff (rst)
        ce && !(hit && reg_rd) |=> !reg_rvalid)
        else $error("read answer without a read");

    a_rx_bypass: assert property (@(posedge clk) disable iff (rst)
        ce |=> rx_fifo_en == $past(ctl_reg[SER_EN_BIT]))
        else $error("rx fifo enable wrong");

    a_tx_fifo_use: assert property (@(posedge clk) disable iff (rst)
        ce && !ser && link_speed != SPEED_1000 |=> !tx_fifo_en)
        else $error("tx fifo enabled outside its modes");

    a_tx_depth: assert property (@(posedge clk) disable iff (rst)
        ce && ctl_reg[TXD_HI:TXD_LO] == 2'h3 |=> tx_fifo_depth == DEPTH_8)
        else $error("tx depth code 11 not eight");

    a_rx_depth: assert property (@(posedge clk) disable iff (rst)
        ce && ctl_reg[RXD_HI:RXD_LO] == 2'h0 |=> rx_fifo_depth == DEPTH_3)
        else $error("rx depth code 00 not three");

    a_strap_load: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> ctl_reg[SER_EN_BIT] == $past(strap_serial) &&
        ctl_reg[PAIR_HI:PAIR_LO] ==
        (PAIR_FROM_STRAP ? $past(strap_pair_swap) : PAIR_RST))
        else $error("strap not loaded at reset");

    a_serial_sel: assert property (@(posedge clk) disable iff (rst)
        ce && hit && reg_wr |=> serial_mode == $past(reg_wdata[SER_EN_BIT]))
        else $error("serial mode not taken from write");

    a_force_link: assert property (@(posedge clk) disable iff (rst)
        ce && hit && reg_wr |=>
        force_link_good == $past(reg_wdata[LINK_OVR_BIT]))
        else $error("forced link not taken from write");

    a_pair_mode: assert property (@(posedge clk) disable iff (rst)
        ce && hit && reg_wr |=>
        auto_pair_swap == $past(reg_wdata[PAIR_HI]) &&
        pair_swap_select == ($past(reg_wdata[PAIR_HI:PAIR_LO]) == PAIR_MDIX))
        else $error("pair assignment not taken from write");

    a_standby: assert property (@(posedge clk) disable iff (rst)
        ce && hit && reg_wr |=> link_block == $past(reg_wdata[STANDBY_BIT]))
        else $error("standby not taken from write");

    a_pol_flip: assert property (@(posedge clk) disable iff (rst)
        ce && hit && reg_wr |=>
        tx_polarity_flip == $past(reg_wdata[POL_FLIP_BIT]))
        else $error("polarity flip not taken from write");

    a_jabber_off: assert property (@(posedge clk) disable iff (rst)
        ce && hit && reg_wr |=> jabber_en == !$past(reg_wdata[JAB_DIS_BIT]))
        else $error("jabber enable not taken from write");

    a_passive_down: assert property (@(posedge clk) disable iff (rst)
        ce && ps_code == PS_PASSIVE ##1 ce |=> blocks_pd)
        else $error("passive sleep left blocks powered");

    a_normal_up: assert property (@(posedge clk) disable iff (rst)
        ce && ps_code == PS_NORMAL ##1 ce |=> !blocks_pd && !pll_pd)
        else $error("normal mode left blocks powered down");

    a_ieee_pll: assert property (@(posedge clk) disable iff (rst)
        ce && pwr_reg == PWR_IEEE && !ctl_reg[CLK_DIS_BIT] |=> pll_pd)
        else $error("pll not powered down in ieee mode");

    a_wake_partner: assert property (@(posedge clk) disable iff (rst)
        ce && pwr_reg == PWR_ACT_SLEEP && ps_code == PS_ACTIVE &&
        partner_detect |=> pwr_reg == PWR_ACT_WAKE && !sleeping)
        else $error("no wake on partner detect");

    a_deep_pd: assert property (@(posedge clk) disable iff (rst)
        ce && pd_req && ctl_reg[DEEP_PD_BIT] |=> deep_pd && !std_pd)
        else $error("deep power-down not entered");

    a_std_pd: assert property (@(posedge clk) disable iff (rst)
        ce && pd_req && !ctl_reg[DEEP_PD_BIT] |=> std_pd && !deep_pd)
        else $error("ordinary power-down not entered");

    a_clk_gate: assert property (@(posedge clk) disable iff (rst)
        ce |=> ref_clock_out_en == !$past(ctl_reg[CLK_DIS_BIT]))
        else $error("clock output gate wrong");

endmodule : pcr_ctrl

// ### common/pcr_pkg.sv
// constants, types and helpers for the transceiver control register
package pcr_pkg;

    // ----------------------------------------
    // address and field layout
    // ----------------------------------------
    localparam logic [4:0]  PCR_ADDR      = 5'h10;
    localparam int          TXD_HI        = 15;
    localparam int          TXD_LO        = 14;
    localparam int          RXD_HI        = 13;
    localparam int          RXD_LO        = 12;
    localparam int          SER_EN_BIT    = 11;
    localparam int          LINK_OVR_BIT  = 10;
    localparam int          PS_HI         = 9;
    localparam int          PS_LO         = 8;
    localparam int          DEEP_PD_BIT   = 7;
    localparam int          PAIR_HI       = 6;
    localparam int          PAIR_LO       = 5;
    localparam int          CLK_DIS_BIT   = 4;
    localparam int          FIXED_BIT     = 3;
    localparam int          STANDBY_BIT   = 2;
    localparam int          POL_FLIP_BIT  = 1;
    localparam int          JAB_DIS_BIT   = 0;

    // ----------------------------------------
    // write mask and reset values
    // ----------------------------------------
    localparam logic [15:0] WR_MASK       = 16'hfff7;
    localparam logic [15:0] FIXED_ONES    = 16'h0008;
    localparam logic [1:0]  TXD_RST       = 2'h1;
    localparam logic [1:0]  RXD_RST       = 2'h1;
    localparam logic [1:0]  PS_RST        = 2'h0;
    localparam logic [1:0]  PAIR_RST      = 2'h2;
    localparam logic        BIT_CLR       = 1'b0;
    localparam logic        BIT_SET       = 1'b1;

    // ----------------------------------------
    // codes
    // ----------------------------------------
    localparam logic [1:0]  PS_NORMAL     = 2'h0;
    localparam logic [1:0]  PS_IEEE       = 2'h1;
    localparam logic [1:0]  PS_ACTIVE     = 2'h2;
    localparam logic [1:0]  PS_PASSIVE    = 2'h3;
    localparam logic [1:0]  PAIR_MDIX     = 2'h1;
    localparam logic [1:0]  SPEED_1000    = 2'h2;
    localparam logic [3:0]  DEPTH_3       = 4'h3;
    localparam logic [3:0]  DEPTH_4       = 4'h4;
    localparam logic [3:0]  DEPTH_6       = 4'h6;
    localparam logic [3:0]  DEPTH_8       = 4'h8;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int          CLK_HZ        = 50_000_000;
    localparam int          LINK_PULSE_MS = 1400;
    localparam int          PULSE_CYCLES  = LINK_PULSE_MS * (CLK_HZ / 1000);
    localparam int          PULSE_W       = 27;

    typedef enum logic [2:0] {
        PWR_NORMAL,
        PWR_IEEE,
        PWR_ACT_SLEEP,
        PWR_ACT_WAKE,
        PWR_PASSIVE
    } pcr_pwr_e;

    // depth code to entry count
    function automatic logic [3:0] pcr_depth(input logic [1:0] code);
        unique case (code)
            2'h3: pcr_depth = DEPTH_8;
            2'h2: pcr_depth = DEPTH_6;
            2'h1: pcr_depth = DEPTH_4;
            2'h0: pcr_depth = DEPTH_3;
        endcase
    endfunction : pcr_depth

endpackage : pcr_pkg

// ### logic/pcr_wake_pulse.sv
// link pulse generator used while in active sleep
`timescale 1ns/10ps
module pcr_wake_pulse
    import pcr_pkg::*;
#(
    parameter int PERIOD = PULSE_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // control
    input  wire logic run,
    // pulse out
    output logic      pulse
);

    // ----------------------------------------
    // period counter
    // ----------------------------------------
    localparam logic [PULSE_W-1:0] LAST = PULSE_W'(PERIOD - 1);
    localparam logic [PULSE_W-1:0] ONE  = PULSE_W'(1);

    logic [PULSE_W-1:0] cnt_reg;
    logic [PULSE_W-1:0] cnt_next;
    logic               pulse_reg;
    logic               pulse_next;

    always_comb begin
        cnt_next   = cnt_reg;
        pulse_next = 1'b0;
        if (!run) begin
            cnt_next = '0;
        end else if (cnt_reg == LAST) begin
            cnt_next   = '0;
            pulse_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg   <= '0;
            pulse_reg <= 1'b0;
        end else if (ce) begin
            cnt_reg   <= cnt_next;
            pulse_reg <= pulse_next;
        end
    end

    assign pulse = pulse_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_pulse_needs_run: assert property (@(posedge clk) disable iff (rst)
        ce && !run |=> !pulse)
        else $error("link pulse while not in active sleep");

    a_pulse_one_cycle: assert property (@(posedge clk) disable iff (rst)
        pulse && ce |=> !pulse)
        else $error("link pulse longer than one cycle");

endmodule : pcr_wake_pulse

// ### verif/pcr_mgmt_model.sv
// management master model driving the register port
`timescale 1ns/10ps
module pcr_mgmt_model (
    // clock
    input  wire logic        clk,
    // register port
    output logic [4:0]       reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    initial begin
        reg_addr  = 5'h0f;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 16'h0000;
    end

    // one-edge write strobe, lines inverted once released
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    // one-edge read strobe, answer taken one cycle later
    task automatic rd(input logic [4:0] a, output logic [15:0] d,
                      output logic ok);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        ok       = (reg_rvalid === 1'b1);
        d        = reg_rdata;
    endtask : rd
endmodule : pcr_mgmt_model

// ### verif/tb_top.sv
// self-checking testbench for the transceiver control register
`timescale 1ns/10ps
module tb_top
    import pcr_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] wdata;
        logic [1:0]  spd;
        logic        gmii;
        logic [1:0]  pd;
        logic [3:0]  txd;
        logic [3:0]  rxd;
        logic [13:0] flags;
    } pcr_row_s;
    pcr_row_s    rows [4] = '{
        '{16'hc000, 2'h2, 1'b1, 2'h0, 4'h8, 4'h3, 14'h2090},
        '{16'hbd2f, 2'h0, 1'b0, 2'h2, 4'h6, 4'h8, 14'h3ded},
        '{16'h61d0, 2'h2, 1'b0, 2'h1, 4'h4, 4'h6, 14'h021a},
        '{16'h0360, 2'h2, 1'b1, 2'h0, 4'h3, 4'h3, 14'h2298}};
    logic        clk = 1'b0;
    logic        rst, ce, strap_serial, mac_gmii_style, partner_detect;
    logic        pd_pin, basic_control_reg_pd, reg_wr, reg_rd, reg_rvalid;
    logic [1:0]  strap_pair_swap, link_speed;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_val;
    logic [3:0]  tx_fifo_depth, rx_fifo_depth;
    logic        tx_fifo_en, rx_fifo_en, serial_mode, force_link_good;
    logic        auto_pair_swap, pair_swap_select, ref_clock_out_en;
    logic        link_block, tx_polarity_flip, jabber_en, blocks_pd, pll_pd;
    logic        deep_pd, std_pd, link_pulse, sleeping, rd_ok;
    logic [13:0] flg_obs;
    int          err_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          pulses;

    assign flg_obs = {tx_fifo_en, rx_fifo_en, serial_mode, force_link_good,
                      auto_pair_swap, pair_swap_select, ref_clock_out_en,
                      link_block, tx_polarity_flip, jabber_en, blocks_pd,
                      pll_pd, deep_pd, std_pd};

    always #10 clk = ~clk;

    pcr_ctrl #(.PAIR_FROM_STRAP(1'b0), .PULSE_PERIOD(16)) uut (
        .clk(clk), .rst(rst), .ce(ce), .strap_serial(strap_serial),
        .strap_pair_swap(strap_pair_swap), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .link_speed(link_speed), .mac_gmii_style(mac_gmii_style),
        .partner_detect(partner_detect), .pd_pin(pd_pin),
        .basic_control_reg_pd(basic_control_reg_pd),
        .tx_fifo_depth(tx_fifo_depth), .tx_fifo_en(tx_fifo_en),
        .rx_fifo_depth(rx_fifo_depth), .rx_fifo_en(rx_fifo_en),
        .serial_mode(serial_mode), .force_link_good(force_link_good),
        .auto_pair_swap(auto_pair_swap),
        .pair_swap_select(pair_swap_select),
        .ref_clock_out_en(ref_clock_out_en), .link_block(link_block),
        .tx_polarity_flip(tx_polarity_flip), .jabber_en(jabber_en),
        .blocks_pd(blocks_pd), .pll_pd(pll_pd), .deep_pd(deep_pd),
        .std_pd(std_pd), .link_pulse(link_pulse), .sleeping(sleeping));

    pcr_mgmt_model mdl (
        .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic count_pulses(input int n);
        pulses = 0;
        for (int k = 0; k < n; k++) begin
            @(negedge clk);
            pulses += int'(link_pulse === 1'b1);
        end
    endtask : count_pulses

    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            err_count++;
            end_sim();
        end
    end

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        strap_serial = 1'b0;
        strap_pair_swap = 2'h0;
        link_speed = 2'h0;
        mac_gmii_style = 1'b0;
        partner_detect = 1'b0;
        pd_pin = 1'b0;
        basic_control_reg_pd = 1'b0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        foreach (rows[i]) begin
            link_speed = rows[i].spd;
            mac_gmii_style = rows[i].gmii;
            {pd_pin, basic_control_reg_pd} = rows[i].pd;
            mdl.wr(PCR_ADDR, rows[i].wdata);
            repeat (4) @(negedge clk);
            mdl.rd(PCR_ADDR, rd_val, rd_ok);
            chk({15'h0, rd_ok}, 16'h0001);
            chk(rd_val, (rows[i].wdata & 16'hfff7) | 16'h0008);
            chk({12'h0, tx_fifo_depth}, {12'h0, rows[i].txd});
            chk({12'h0, rx_fifo_depth}, {12'h0, rows[i].rxd});
            chk({2'h0, flg_obs}, {2'h0, rows[i].flags});
        end
        // unmapped address and held clock enable leave register alone
        mdl.wr(5'h11, 16'hffff);
        mdl.rd(5'h11, rd_val, rd_ok);
        chk({15'h0, rd_ok}, 16'h0000);
        ce = 1'b0;
        mdl.wr(PCR_ADDR, 16'h0000);
        ce = 1'b1;
        mdl.rd(PCR_ADDR, rd_val, rd_ok);
        chk(rd_val, 16'h0368);
        // active sleep: pulses, then wake on partner
        {pd_pin, basic_control_reg_pd} = 2'h0;
        link_speed = 2'h1;
        mdl.wr(PCR_ADDR, 16'h5248);
        repeat (3) @(negedge clk);
        chk({13'h0, tx_fifo_en, sleeping, blocks_pd}, 16'h0003);
        count_pulses(34);
        chk(16'(pulses), 16'h0002);
        partner_detect = 1'b1;
        repeat (3) @(negedge clk);
        chk({14'h0, sleeping, blocks_pd}, 16'h0000);
        count_pulses(20);
        chk(16'(pulses), 16'h0000);
        // write directly followed by read
        mdl.wr(PCR_ADDR, 16'h1234);
        mdl.rd(PCR_ADDR, rd_val, rd_ok);
        chk(rd_val, 16'h123c);
        // reset with serial strap set
        rst = 1'b1;
        strap_serial = 1'b1;
        strap_pair_swap = 2'h1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        mdl.rd(PCR_ADDR, rd_val, rd_ok);
        chk(rd_val, 16'h5848);
        chk({8'h0, tx_fifo_depth, rx_fifo_depth}, 16'h0044);
        chk({10'h0, tx_fifo_en, serial_mode, rx_fifo_en, ref_clock_out_en,
             auto_pair_swap, jabber_en}, 16'h003f);
        end_sim();
    end
endmodule : tb_top
